/* include/rtci_consts.vh */
// Constants for the interrupt, oscillator control and rate logic of the clock.
// Assumes a 125 MHz core clock and a host that drives the byte-wide bus pins.
//
// Overview of operation
// - Year rollover loads BCD 20 into century
// - Century load keeps the written top bit
// - General RAM is always readable and writable
// - Disabled source never drives the interrupt
// - Enabling with flag already set interrupts
// - Flags set on events regardless of enables
// - Flag register latched stable during read
// - Events during flag read posted afterwards
// - Flag read clears flags and releases interrupt
// - Interrupt held while enabled flag set
// - Bit 7 reads one while interrupt low
// - Pattern 010 runs oscillator and chain
// - Pattern 11x runs oscillator, chain reset
// - Other patterns keep the oscillator stopped
// - One tap multiplexer feeds both generators
// - Square-wave enable gates only the pin
// - Rate field sets both, enable gates interrupt
// - Code 0 off, 3..15 double interval
// - Codes 1 and 2 repeat 8 and 9
// - Update end sets flag bit 4 and pulses update_end
// - Disabled square-wave pin holds low
// - Periodic flag set on each rising tap edge
// - Rate field in bits 3 to 0
// - Low flag bits read zero, ignore writes

`ifndef RTCI_CONSTS_VH
`define RTCI_CONSTS_VH

// ----------------------------------------------------------------------------
// Register locations
// ----------------------------------------------------------------------------
`define RTCI_ADDR_CTRL_A     7'h0A
`define RTCI_ADDR_CTRL_B     7'h0B
`define RTCI_ADDR_FLAGS      7'h0C
`define RTCI_ADDR_STATUS_D   7'h0D
`define RTCI_ADDR_CENTURY    7'h32

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RTCI_A_UPDATE_BIT    7
`define RTCI_A_OSC_HI        6
`define RTCI_A_OSC_LO        4
`define RTCI_A_RATE_HI       3
`define RTCI_A_RATE_LO       0
`define RTCI_B_SET_BIT       7
`define RTCI_B_PER_EN_BIT    6
`define RTCI_B_ALM_EN_BIT    5
`define RTCI_B_UPD_EN_BIT    4
`define RTCI_B_SQW_EN_BIT    3

// ----------------------------------------------------------------------------
// Values and reset values
// ----------------------------------------------------------------------------
`define RTCI_OSC_RUN         3'h2
`define RTCI_CENTURY_LOAD    7'h20
`define RTCI_CTRL_A_RESET    8'h00
`define RTCI_CTRL_B_RESET    8'h00
`define RTCI_STATUS_D        8'h80
`define RTCI_CENTURY_RESET   8'h00

// ----------------------------------------------------------------------------
// Timing: crystal rate in Hz, core clock in Hz
// ----------------------------------------------------------------------------
`define RTCI_XTAL_HZ         32768
`define RTCI_CLK_HZ          125000000
`define RTCI_XTAL_DIV        (`RTCI_CLK_HZ / `RTCI_XTAL_HZ)

`endif

/* design/rtci_top.v */
// Interrupt flags, oscillator control, rate multiplexer, century load and
// general RAM of a byte-wide real-time clock.
// Assumes bus pins settle before their strobes and that time counting logic
// on this clock supplies one-cycle year_rollover and alarm_match pulses.
`timescale 1ns/1ps
`include "rtci_consts.vh"

module rtci_top #(
   parameter integer XTAL_DIV = `RTCI_XTAL_DIV
) (
   // Clock and reset
   input  wire       clk,
   input  wire       nrst,
   // Host bus pins, asynchronous to clk
   input  wire       bus_cs,
   input  wire       bus_rd,
   input  wire       bus_wr,
   input  wire [6:0] bus_addr,
   input  wire [7:0] bus_wdata,
   output wire [7:0] bus_rdata,
   // Events from time counting logic
   input  wire       year_rollover,
   input  wire       alarm_match,
   // Pins and status
   output wire       irq_n,
   output wire       square_wave_pin,
   output wire       osc_running,
   output wire       chain_in_reset,
   output wire       update_end
);

   // ----------------------------------------------------------------------------
   // Tap selection for a rate code; zero means no output
   // ----------------------------------------------------------------------------
   function tap_of;
      input [3:0]  code;
      input [14:0] div;
      reg   [3:0]  eff;
      begin
         eff = code;
         if (code == 4'h1) begin
            eff = 4'h8;
         end else if (code == 4'h2) begin
            eff = 4'h9;
         end
         if (eff < 4'h3) begin
            tap_of = 1'b0;
         end else begin
            tap_of = div[eff - 4'h2];
         end
      end
   endfunction

   // ----------------------------------------------------------------------------
   // Bus pin synchronisers
   // ----------------------------------------------------------------------------
   reg  [17:0] pin_meta_reg;
   reg  [17:0] pin_sync_reg;
   wire        s_cs;
   wire        s_rd;
   wire        s_wr;
   wire [6:0]  s_addr;
   wire [7:0]  s_wdata;

   // Two flops before anything reads a host pin
   always @(posedge clk) begin
      if (!nrst) begin
         pin_meta_reg <= 18'h00000;
         pin_sync_reg <= 18'h00000;
      end else begin
         pin_meta_reg <= {bus_cs, bus_rd, bus_wr, bus_addr, bus_wdata};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign s_cs    = pin_sync_reg[17];
   assign s_rd    = pin_sync_reg[16];
   assign s_wr    = pin_sync_reg[15];
   assign s_addr  = pin_sync_reg[14:8];
   assign s_wdata = pin_sync_reg[7:0];

   // ----------------------------------------------------------------------------
   // Access strobes
   // ----------------------------------------------------------------------------
   reg  rd_act_reg;
   reg  wr_act_reg;
   reg  rd_flag_reg;
   wire flag_rd_start;
   wire rd_now;
   wire rd_start;
   wire rd_end;
   wire wr_start;

   assign rd_now   = s_cs & s_rd;
   assign rd_start = rd_now & ~rd_act_reg;
   assign rd_end   = ~rd_now & rd_act_reg;
   assign wr_start = s_cs & s_wr & ~wr_act_reg;
   assign flag_rd_start = rd_start & (s_addr == `RTCI_ADDR_FLAGS);

   // Edge history of the read and write strobes
   always @(posedge clk) begin
      if (!nrst) begin
         rd_act_reg  <= 1'b0;
         wr_act_reg  <= 1'b0;
         rd_flag_reg <= 1'b0;
      end else begin
         rd_act_reg  <= rd_now;
         wr_act_reg  <= s_cs & s_wr;
         // Remember a flag read: the host may move the address as it drops the strobe
         rd_flag_reg <= (rd_flag_reg & ~rd_end) | flag_rd_start;
      end
   end

   // ----------------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------------
   reg  [7:0] ctrl_a_reg;
   reg  [7:0] ctrl_b_reg;
   reg  [7:0] century_reg;
   wire [2:0] osc_field;
   wire [3:0] rate_field;
   wire       osc_on;
   wire       chain_rst;
   wire [2:0] enables;

   assign osc_field  = ctrl_a_reg[`RTCI_A_OSC_HI:`RTCI_A_OSC_LO];
   assign rate_field = ctrl_a_reg[`RTCI_A_RATE_HI:`RTCI_A_RATE_LO];
   // Only 010 and 11x run the oscillator; 11x holds the chain
   assign chain_rst  = osc_field[2] & osc_field[1];
   assign osc_on     = (osc_field == `RTCI_OSC_RUN) | chain_rst;
   // Enable order matches flag order: periodic, alarm, update end
   assign enables    = {ctrl_b_reg[`RTCI_B_PER_EN_BIT], ctrl_b_reg[`RTCI_B_ALM_EN_BIT],
                        ctrl_b_reg[`RTCI_B_UPD_EN_BIT]};

   // Host writes; the update bit of A is status and never stored
   always @(posedge clk) begin
      if (!nrst) begin
         ctrl_a_reg <= `RTCI_CTRL_A_RESET;
         ctrl_b_reg <= `RTCI_CTRL_B_RESET;
      end else if (wr_start && s_addr == `RTCI_ADDR_CTRL_A) begin
         ctrl_a_reg <= {1'b0, s_wdata[6:0]};
      end else if (wr_start && s_addr == `RTCI_ADDR_CTRL_B) begin
         ctrl_b_reg <= s_wdata;
         // Setting the hold bit drops the update-end enable
         if (s_wdata[`RTCI_B_SET_BIT]) begin
            ctrl_b_reg[`RTCI_B_UPD_EN_BIT] <= 1'b0;
         end
      end
   end

   // Century byte: a rollover load keeps the written top bit
   always @(posedge clk) begin
      if (!nrst) begin
         century_reg <= `RTCI_CENTURY_RESET;
      end else if (year_rollover) begin
         century_reg <= {century_reg[7], `RTCI_CENTURY_LOAD};
      end else if (wr_start && s_addr == `RTCI_ADDR_CENTURY) begin
         century_reg <= s_wdata;
      end
   end

   // ----------------------------------------------------------------------------
   // General RAM
   // ----------------------------------------------------------------------------
   reg [7:0] ram_mem [0:127];

   // No update interlock: the host may reach these bytes at any time
   always @(posedge clk) begin
      if (wr_start && s_addr != `RTCI_ADDR_CTRL_A && s_addr != `RTCI_ADDR_CTRL_B &&
          s_addr != `RTCI_ADDR_FLAGS && s_addr != `RTCI_ADDR_STATUS_D &&
          s_addr != `RTCI_ADDR_CENTURY) begin
         ram_mem[s_addr] <= s_wdata;
      end
   end

   // ----------------------------------------------------------------------------
   // Crystal emulation and divider chain
   // ----------------------------------------------------------------------------
   reg  [11:0] xtal_cnt_reg;
   reg  [14:0] div_reg;
   reg         tap_prev_reg;
   reg         sec_prev_reg;
   wire        xtal_tick;
   wire        tap;
   wire        per_event;
   wire        upd_event;

   // The crystal is modelled as a tick every XTAL_DIV core cycles
   assign xtal_tick = (xtal_cnt_reg == XTAL_DIV[11:0] - 12'h001);

   always @(posedge clk) begin
      if (!nrst || !osc_on) begin
         xtal_cnt_reg <= 12'h000;
      end else if (xtal_tick) begin
         xtal_cnt_reg <= 12'h000;
      end else begin
         xtal_cnt_reg <= xtal_cnt_reg + 12'h001;
      end
   end

   // Fifteen-stage count-up chain, cleared to zero while stopped or in reset
   always @(posedge clk) begin
      if (!nrst || !osc_on || chain_rst) begin
         div_reg <= 15'h0000;
      end else if (xtal_tick) begin
         div_reg <= div_reg + 15'h0001;
      end
   end

   // One multiplexer output feeds both the pin and the periodic flag
   assign tap       = tap_of(rate_field, div_reg);
   assign per_event = tap & ~tap_prev_reg;
   // The one-second stage falling marks the end of an update cycle
   assign upd_event = ~div_reg[14] & sec_prev_reg;

   always @(posedge clk) begin
      if (!nrst) begin
         tap_prev_reg <= 1'b0;
         sec_prev_reg <= 1'b0;
      end else begin
         tap_prev_reg <= tap;
         sec_prev_reg <= div_reg[14];
      end
   end

   // ----------------------------------------------------------------------------
   // Square-wave pin
   // ----------------------------------------------------------------------------
   reg sqw_reg;

   // The tap itself has even halves; disabled pin sits low
   always @(posedge clk) begin
      if (!nrst) begin
         sqw_reg <= 1'b0;
      end else begin
         sqw_reg <= ctrl_b_reg[`RTCI_B_SQW_EN_BIT] & tap;
      end
   end

   // ----------------------------------------------------------------------------
   // Interrupt flags
   // ----------------------------------------------------------------------------
   reg  [2:0] flag_reg;
   reg  [2:0] pend_reg;
   reg  [7:0] snap_reg;
   reg        irq_n_reg;
   reg        upd_pulse_reg;
   wire [2:0] events;

   assign events = {per_event, alarm_match, upd_event};

   // Flags follow events whatever the enables; a read in progress parks
   // new events so the latched value cannot change under the host
   always @(posedge clk) begin
      if (!nrst) begin
         flag_reg <= 3'h0;
         pend_reg <= 3'h0;
      end else if (rd_flag_reg && rd_end) begin
         flag_reg <= pend_reg | events;
         pend_reg <= 3'h0;
      end else if (rd_flag_reg || flag_rd_start) begin
         pend_reg <= pend_reg | events;
      end else begin
         flag_reg <= flag_reg | pend_reg | events;
         pend_reg <= 3'h0;
      end
   end

   // Interrupt pin is the OR of enabled flags, so enabling a set flag
   // fires at once; stale flags are the host's to clear first
   always @(posedge clk) begin
      if (!nrst) begin
         irq_n_reg <= 1'b1;
      end else begin
         irq_n_reg <= ~|(flag_reg & enables);
      end
   end

   // Update-end strobe for the time logic
   always @(posedge clk) begin
      if (!nrst) begin
         upd_pulse_reg <= 1'b0;
      end else begin
         upd_pulse_reg <= upd_event;
      end
   end

   // ----------------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------------
   reg [7:0] rdata_reg;
   reg [7:0] rdata_next;

   // Read mux; the flag byte comes from the snapshot taken at read start
   always @* begin
      case (s_addr)
         `RTCI_ADDR_CTRL_A:   rdata_next = {1'b0, ctrl_a_reg[6:0]};
         `RTCI_ADDR_CTRL_B:   rdata_next = ctrl_b_reg;
         `RTCI_ADDR_FLAGS:    rdata_next = snap_reg;
         `RTCI_ADDR_STATUS_D: rdata_next = `RTCI_STATUS_D;
         `RTCI_ADDR_CENTURY:  rdata_next = century_reg;
         default:             rdata_next = ram_mem[s_addr];
      endcase
   end

   // Double latch of the flag byte: frozen for the whole read
   always @(posedge clk) begin
      if (!nrst) begin
         snap_reg <= 8'h00;
      end else if (rd_start) begin
         snap_reg <= {~irq_n_reg, flag_reg, 4'h0};
      end
   end

   // Drive read data while a read is active, zero otherwise; the strobe's
   // falling cycle already gives zero so a moved address never leaks out
   always @(posedge clk) begin
      if (!nrst) begin
         rdata_reg <= 8'h00;
      end else if (rd_act_reg && rd_now) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // ----------------------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------------------
   reg osc_run_reg;
   reg chain_rst_reg;

   always @(posedge clk) begin
      if (!nrst) begin
         osc_run_reg   <= 1'b0;
         chain_rst_reg <= 1'b0;
      end else begin
         osc_run_reg   <= osc_on;
         chain_rst_reg <= chain_rst;
      end
   end

   assign bus_rdata       = rdata_reg;
   assign irq_n           = irq_n_reg;
   assign square_wave_pin = sqw_reg;
   assign osc_running     = osc_run_reg;
   assign chain_in_reset  = chain_rst_reg;
   assign update_end      = upd_pulse_reg;

endmodule // rtci_top

/* testbench/rtci_checker_assertions.sv */
// Port checker for the interrupt, oscillator and rate block.
// Assumes host strobes stay high and low for several cycles.
`timescale 1ns/1ps
`include "rtci_consts.vh"
module rtci_checker #(
   parameter integer XTAL_DIV = 2
) (
   // Clock and reset
   input wire       clk,
   input wire       nrst,
   // Host bus
   input wire       bus_cs,
   input wire       bus_rd,
   input wire [6:0] bus_addr,
   input wire [7:0] bus_rdata,
   // Pins and status
   input wire       irq_n,
   input wire       square_wave_pin,
   input wire       osc_running,
   input wire       chain_in_reset,
   input wire       update_end
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // A flag read on the pins, up to the fall of its strobe
   sequence flag_read_end_s;
      bus_cs && bus_rd && bus_addr == `RTCI_ADDR_FLAGS ##1 !bus_rd;
   endsequence
   // Oscillator stopped long enough for the divider to freeze
   sequence stopped_s;
      !osc_running [*3];
   endsequence
   reset_clear_a: assert property (disable iff (1'b0) !nrst |=> irq_n && !square_wave_pin && !osc_running)
      else $error("outputs not cleared by reset");
   chain_needs_osc_a: assert property (chain_in_reset |-> osc_running)
      else $error("chain held in reset without oscillator");
   stop_no_update_a: assert property (stopped_s |-> !update_end)
      else $error("update end with oscillator stopped");
   stop_no_wave_a: assert property (stopped_s |-> !$rose(square_wave_pin))
      else $error("square wave rose with oscillator stopped");
   rdata_idle_a: assert property (!bus_rd [*5] |-> bus_rdata == 8'h00)
      else $error("read data not zero while idle");
   flag_low_zero_a: assert property (bus_cs && bus_rd && bus_addr == `RTCI_ADDR_FLAGS |-> bus_rdata[3:0] == 4'h0)
      else $error("low flag bits not zero");
   irq_release_a: assert property (flag_read_end_s |-> ##[1:6] irq_n)
      else $error("interrupt not released after flag read");
   status_read_a: assert property ($rose(bus_rd) && bus_cs && bus_addr == `RTCI_ADDR_STATUS_D |-> ##[3:6] bus_rdata == 8'h80)
      else $error("status read data wrong");
endmodule // rtci_checker

bind rtci_top rtci_checker #(.XTAL_DIV(XTAL_DIV)) u_rtci_checker (
   .clk             (clk),
   .nrst            (nrst),
   .bus_cs          (bus_cs),
   .bus_rd          (bus_rd),
   .bus_addr        (bus_addr),
   .bus_rdata       (bus_rdata),
   .irq_n           (irq_n),
   .square_wave_pin (square_wave_pin),
   .osc_running     (osc_running),
   .chain_in_reset  (chain_in_reset),
   .update_end      (update_end)
);

/* testbench/rtci_host_model.sv */
// Host processor model on the byte-wide bus pins.
// Assumes the bench calls its tasks; pins change at the falling edge.
`timescale 1ns/1ps
`include "rtci_consts.vh"
module rtci_host_model (
   // Clock
   input  wire       clk,
   // Bus pins
   output reg        bus_cs,
   output reg        bus_rd,
   output reg        bus_wr,
   output reg  [6:0] bus_addr,
   output reg  [7:0] bus_wdata,
   input  wire [7:0] bus_rdata
);
   // Idle bus at time zero
   initial begin
      bus_cs = 1'b0;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_addr = 7'h00;
      bus_wdata = 8'h00;
   end
   // Released lines show the inverse, so stale values are never trusted
   task release_bus;
      begin
         bus_cs = 1'b0;
         bus_rd = 1'b0;
         bus_wr = 1'b0;
         bus_addr = ~bus_addr;
         bus_wdata = ~bus_wdata;
         repeat (6) @(negedge clk);
      end
   endtask
   // Strobes held six cycles so the two-flop sync sees them
   task wr_reg(input [6:0] a, input [7:0] d);
      begin
         @(negedge clk);
         bus_addr = a;
         bus_wdata = d;
         bus_cs = 1'b1;
         bus_wr = 1'b1;
         repeat (6) @(negedge clk);
         release_bus;
      end
   endtask
   task rd_reg(input [6:0] a, output [7:0] d);
      begin
         @(negedge clk);
         bus_addr = a;
         bus_cs = 1'b1;
         bus_rd = 1'b1;
         repeat (6) @(negedge clk);
         d = bus_rdata;
         release_bus;
      end
   endtask
   // Stale flags are read away before enables are written
   task enable_clean(input [7:0] en);
      reg [7:0] v;
      begin
         rd_reg(`RTCI_ADDR_FLAGS, v);
         wr_reg(`RTCI_ADDR_CTRL_B, en);
      end
   endtask
endmodule // rtci_host_model

/* testbench/tb_rtc_interrupt_rate_logic.sv */
// Testbench for the interrupt, oscillator and rate block.
// Assumes the host model and the bound checker alongside.
`timescale 1ns/1ps
`include "rtci_consts.vh"
module tb_rtc_interrupt_rate_logic;
   localparam integer xtal = 2;
   localparam [6:0] ra = `RTCI_ADDR_CTRL_A;
   localparam [6:0] rb = `RTCI_ADDR_CTRL_B;
   localparam [6:0] rc = `RTCI_ADDR_FLAGS;
   reg        clk = 1'b0;
   reg        nrst;
   reg        year_rollover;
   reg        alarm_match;
   wire       bus_cs, bus_rd, bus_wr, irq_n, square_wave_pin;
   wire       osc_running, chain_in_reset, update_end;
   wire [6:0] bus_addr;
   wire [7:0] bus_wdata, bus_rdata;
   integer    failures, checked;
   // Design and host partner
   rtci_top #(.XTAL_DIV(xtal)) u_rtci_top (.clk(clk), .nrst(nrst), .bus_cs(bus_cs),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .year_rollover(year_rollover), .alarm_match(alarm_match),
      .irq_n(irq_n), .square_wave_pin(square_wave_pin), .osc_running(osc_running),
      .chain_in_reset(chain_in_reset), .update_end(update_end));
   rtci_host_model u_rtci_host_model (.clk(clk), .bus_cs(bus_cs), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
   // 125 MHz clock
   always #4 clk = ~clk;
   task finish_test;
      begin
         $display("checked %0d failures %0d", checked, failures);
         if (failures == 0 && checked > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task check(input string what, input [15:0] seen, input [15:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected %0s: expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask
   task wr(input [6:0] a, input [7:0] d);
      u_rtci_host_model.wr_reg(a, d);
   endtask
   task rd_chk(input [6:0] a, input [7:0] e);
      reg [7:0] v;
      begin
         u_rtci_host_model.rd_reg(a, v);
         check("read data", v, e);
      end
   endtask
   // One-cycle event pulse: year rollover or alarm match
   task pulse(input yr);
      begin
         @(negedge clk);
         if (yr) year_rollover = 1'b1;
         else alarm_match = 1'b1;
         @(negedge clk);
         year_rollover = 1'b0;
         alarm_match = 1'b0;
      end
   endtask
   // Length of one full high phase of the square wave, bounded
   task high_len(output integer n);
      integer i;
      begin
         n = 0;
         i = 0;
         while (square_wave_pin !== 1'b0 && i < 3000) begin @(negedge clk); i = i + 1; end
         while (square_wave_pin !== 1'b1 && i < 3000) begin @(negedge clk); i = i + 1; end
         while (square_wave_pin === 1'b1 && i < 3000) begin @(negedge clk); i = i + 1; n = n + 1; end
         if (i >= 3000) begin
            failures = failures + 1;
            finish_test;
         end
      end
   endtask
   task high_count(output integer n);
      begin
         n = 0;
         repeat (300) begin @(negedge clk); n = n + (square_wave_pin !== 1'b0); end
      end
   endtask
   task t_reset;
      begin
         check("irq_n", irq_n, 1);
         check("square_wave_pin", square_wave_pin, 0);
         check("osc_running", osc_running, 0);
         rd_chk(rc, 8'h00);
         rd_chk(`RTCI_ADDR_STATUS_D, 8'h80);
      end
   endtask
   task t_osc;
      integer p;
      begin
         for (p = 0; p < 8; p = p + 1) begin
            wr(ra, {1'b0, p[2:0], 4'h0});
            check("osc_running", osc_running, p == 2 || p >= 6);
            check("chain_in_reset", chain_in_reset, p >= 6);
         end
      end
   endtask
   // Codes 3, 1, 2, 8: fastest tap and the duplicated codes
   task t_sqw;
      integer i, c, k, n;
      begin
         wr(rb, 8'h08);
         for (i = 0; i < 4; i = i + 1) begin
            c = (16'h8213 >> (4 * i)) & 15;
            k = (c < 3) ? c + 5 : c - 2;
            wr(ra, 8'h20 | c);
            high_len(n);
            check("square high", n, xtal << k);
         end
         check("irq_n", irq_n, 1);
         rd_chk(rc, 8'h40);
         wr(rb, 8'h00);
         high_count(n);
         check("square off", n, 0);
         wr(ra, 8'h20);
         wr(rb, 8'h08);
         high_count(n);
         check("square code 0", n, 0);
         wr(rb, 8'h00);
         rd_chk(rc, 8'h40);
         rd_chk(rc, 8'h00);
      end
   endtask
   task t_flags;
      reg [7:0] v;
      begin
         pulse(0);
         check("irq_n", irq_n, 1);
         rd_chk(rc, 8'h20);
         rd_chk(rc, 8'h00);
         fork
            u_rtci_host_model.rd_reg(rc, v);
            begin repeat (5) @(negedge clk); pulse(0); end
         join
         check("flags in read", v, 8'h00);
         rd_chk(rc, 8'h20);
         pulse(0);
         wr(rb, 8'h20);
         check("irq_n", irq_n, 0);
         repeat (20) @(negedge clk);
         check("irq_n", irq_n, 0);
         rd_chk(rc, 8'hA0);
         check("irq_n", irq_n, 1);
         wr(rb, 8'h00);
         pulse(0);
         u_rtci_host_model.enable_clean(8'h20);
         check("irq_n", irq_n, 1);
         pulse(0);
         repeat (3) @(negedge clk);
         check("irq_n", irq_n, 0);
         rd_chk(rc, 8'hA0);
         wr(rb, 8'h00);
      end
   endtask
   task t_store;
      begin
         wr(`RTCI_ADDR_CENTURY, 8'h80);
         pulse(1);
         rd_chk(`RTCI_ADDR_CENTURY, 8'hA0);
         wr(`RTCI_ADDR_CENTURY, 8'h13);
         pulse(1);
         rd_chk(`RTCI_ADDR_CENTURY, 8'h20);
         wr(7'h40, 8'h5A);
         wr(7'h7F, 8'hA5);
         rd_chk(7'h40, 8'h5A);
         rd_chk(7'h7F, 8'hA5);
         wr(rc, 8'hFF);
         rd_chk(rc, 8'h00);
         wr(ra, 8'h2F);
         rd_chk(ra, 8'h2F);
      end
   endtask
   // Update end one full second after a fresh chain start
   task t_update;
      reg [7:0] v;
      integer   n;
      begin
         wr(ra, 8'h70);
         u_rtci_host_model.rd_reg(rc, v);
         wr(ra, 8'h20);
         n = 0;
         while (update_end !== 1'b1 && n < 70000) begin
            @(negedge clk);
            n = n + 1;
         end
         check("update_end", update_end, 1);
         if (n >= 70000) finish_test;
         check("update latency", n > 65500 && n < 65560, 1);
         rd_chk(rc, 8'h10);
      end
   endtask
   // Main sequence
   initial begin
      nrst = 1'b0;
      year_rollover = 1'b0;
      alarm_match = 1'b0;
      failures = 0;
      checked = 0;
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      t_reset;
      t_osc;
      t_sqw;
      t_flags;
      t_store;
      t_update;
      finish_test;
   end
endmodule // tb_rtc_interrupt_rate_logic
